// file: hw/mrsc_top.sv
// Purpose: run/stop and direction arbitration for a brushless driver
// Assumes: single 20 MHz clock, asynchronous active-low reset
// Notes:   switch and run inputs are filtered before any decision
`timescale 1ns/1ns
`default_nettype none

// Operation
// - setting off: only panel controls start and stop the motor
// - setting on: external inputs start/stop, panel controls stay live
// - external-only: external inputs start/stop; switch, direction, dial ignored
// - setting on: run needs external run input and operation switch at run
// - setting on: switch to halt position decelerates despite external run
// - setting on: dial turn updates commanded speed
// - setting on: direction switch change reverses rotation
// - external-only: operation or direction switch actuation shows lockout
// - external-only: dial turn in speed/alarm/warning monitor shows lockout
// - external-only: lockout shown while operation switch sits at run
// - external-only: lockout shown two seconds after direction or dial action
// - external-only: data, parameter and I/O monitor views remain usable
// - external control: exactly one run input asserted rotates motor
// - releasing the run input gives a decelerated stop
// - both run inputs asserted stop instantly without ramp
// - single-speed external run uses the first stored speed entry
// - blink while dialed speed unconfirmed; dial press stores speed
// - panel mode: switch back to run restarts at stored speed
// - panel mode: direction change accepted while running
// - lock function active: dial speed changes ignored
// - external-only: direction taken as switch forward position
// - forward input clockwise, reverse counterclockwise; switch swaps both
module mrsc_top
  import mrsc_pkg::*;
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  // external run inputs
  input  wire logic               forwardRunInput,
  input  wire logic               reverseRunInput,
  // front panel
  input  wire logic               opSwitchRun,
  input  wire logic               dirSwitchRev,
  input  wire logic               dialPress,
  input  wire logic [SPEED_W-1:0] dialSpeed,
  // configuration
  input  wire logic [1:0]         extOpMode,
  input  wire logic               lockFunction,
  input  wire logic               monitorSpeedView,
  input  wire logic               settingViewActive,
  // motor command and display
  output logic                    motorRun,
  output logic                    motorDecel,
  output logic                    motorBrake,
  output logic                    motorCcw,
  output logic [SPEED_W-1:0]      motorSpeed,
  output logic                    lockoutShow,
  output logic                    displayBlink
);

  mrsc_state_all_t q_r;
  mrsc_state_all_t q_nxt;
  logic [NUM_IN-1:0] rawIn;
  logic [SPEED_W-1:0] dialSync_r;

  assign rawIn = {dialPress, dirSwitchRev, opSwitchRun,
                  reverseRunInput, forwardRunInput};

  // dial value is a multi-bit word held stable by the panel encoder
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dialSync_r <= SPEED_RST;
    end else begin
      dialSync_r <= dialSpeed;
    end
  end

  always_comb begin
    logic forward_run_input;
    logic reverse_run_input;
    logic opRun;
    logic dirRev;
    logic press;
    logic extRun;
    logic panelRun;
    logic wantRun;
    logic dirEff;
    logic dialMoved;
    logic extCtl;
    forward_run_input = 1'b0;
    reverse_run_input = 1'b0;
    opRun = 1'b0;
    dirRev = 1'b0;
    press = 1'b0;
    extRun = 1'b0;
    panelRun = 1'b0;
    wantRun = 1'b0;
    dirEff = 1'b0;
    dialMoved = 1'b0;
    extCtl = 1'b0;
    q_nxt = q_r;
    q_nxt.s1 = rawIn;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    // accept a change once stable for the debounce interval
    for (int i = 0; i < NUM_IN; i++) begin
      if (q_r.s2[i] != q_r.s3[i] || q_r.s3[i] == q_r.clean[i]) begin
        q_nxt.cnt[i] = 22'h00_0000;
      end else if (q_r.cnt[i] == 22'(DEBOUNCE_CYC - 1)) begin
        q_nxt.clean[i] = q_r.s3[i];
        q_nxt.cnt[i]   = 22'h00_0000;
      end else begin
        q_nxt.cnt[i] = q_r.cnt[i] + 22'h00_0001;
      end
    end
    forward_run_input    = q_r.clean[IDX_FWD];
    reverse_run_input    = q_r.clean[IDX_REV];
    opRun  = q_r.clean[IDX_OPSW];
    dirRev = q_r.clean[IDX_DIRSW];
    press  = q_r.clean[IDX_DIAL] & ~q_r.prevDial;
    q_nxt.prevOp   = opRun;
    q_nxt.prevDir  = dirRev;
    q_nxt.prevDial = q_r.clean[IDX_DIAL];
    q_nxt.dialSpeedPrev = dialSync_r;
    dialMoved = dialSync_r != q_r.dialSpeedPrev;
    extCtl = extOpMode == MODE_EXT_ON || extOpMode == MODE_EXT_ONLY;
    extRun = forward_run_input ^ reverse_run_input;

    // dial handling: ignored when locked or external-only
    if (extOpMode != MODE_EXT_ONLY && !lockFunction) begin
      if (dialMoved) begin
        q_nxt.unconfirmed = 1'b1;
        if (extOpMode == MODE_EXT_ON) begin
          q_nxt.storedSpeed = dialSync_r;
        end
      end
      if (press) begin
        q_nxt.storedSpeed = dialSync_r;
        q_nxt.unconfirmed = 1'b0;
      end
    end
    if (extOpMode == MODE_EXT_ONLY) begin
      q_nxt.unconfirmed = 1'b0;
    end

    // direction: switch frozen to forward in external-only
    if (extOpMode == MODE_EXT_ONLY) begin
      dirEff = 1'b0;
    end else begin
      dirEff = dirRev;
    end

    case (extOpMode)
      MODE_EXT_ON: wantRun = extRun & opRun;
      MODE_EXT_ONLY: wantRun = extRun;
      default: wantRun = opRun;
    endcase
    panelRun = wantRun;
    if (extCtl && wantRun) begin
      q_nxt.ccwHold = reverse_run_input ^ dirEff;
    end else if (!extCtl && wantRun) begin
      q_nxt.ccwHold = dirEff;
    end

    case (q_r.st)
      ST_RUN: begin
        if (extCtl && forward_run_input && reverse_run_input) begin
          q_nxt.st = ST_STOP;
        end else if (!panelRun) begin
          q_nxt.st = ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (extCtl && forward_run_input && reverse_run_input) begin
          q_nxt.st = ST_STOP;
        end else if (panelRun) begin
          q_nxt.st = ST_RUN;
        end
      end
      ST_STOP: begin
        if (panelRun) begin
          q_nxt.st = ST_RUN;
        end
      end
      default: q_nxt.st = ST_STOP;
    endcase

    q_nxt.cmd.run   = q_nxt.st == ST_RUN;
    q_nxt.cmd.decel = q_nxt.st == ST_DECEL;
    q_nxt.cmd.brake = extCtl && forward_run_input && reverse_run_input;
    q_nxt.cmd.ccw   = q_nxt.ccwHold;
    q_nxt.cmd.speed = q_nxt.storedSpeed;

    // lockout indication in external-only mode
    if (extOpMode == MODE_EXT_ONLY) begin
      if ((dirRev != q_r.prevDir) || (opRun != q_r.prevOp)
          || press
          || (dialMoved && monitorSpeedView && !settingViewActive)) begin
        q_nxt.lockCnt = 26'(LOCKOUT_CYC);
      end else if (q_r.lockCnt != 26'h000_0000) begin
        q_nxt.lockCnt = q_r.lockCnt - 26'h000_0001;
      end
      q_nxt.lockout = opRun || q_nxt.lockCnt != 26'h000_0000;
    end else begin
      q_nxt.lockCnt = 26'h000_0000;
      q_nxt.lockout = 1'b0;
    end
    q_nxt.blink = q_nxt.unconfirmed;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_r <= '0;
      q_r.st <= ST_STOP;
      q_r.storedSpeed <= SPEED_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign motorRun     = q_r.cmd.run;
  assign motorDecel   = q_r.cmd.decel;
  assign motorBrake   = q_r.cmd.brake;
  assign motorCcw     = q_r.cmd.ccw;
  assign motorSpeed   = q_r.cmd.speed;
  assign lockoutShow  = q_r.lockout;
  assign displayBlink = q_r.blink;

  // both run inputs give an instant stop, never a ramp
  sequence bothIn_s;
    q_r.clean[IDX_FWD] && q_r.clean[IDX_REV]
      && (extOpMode == MODE_EXT_ON || extOpMode == MODE_EXT_ONLY);
  endsequence
  property instStop_p;
    @(posedge core_clk) disable iff (!arst_n)
      bothIn_s |=> (motorBrake && !motorRun && !motorDecel);
  endproperty
  inst_stop_a: assert property (instStop_p)
    else $error("both run inputs did not stop instantly");

  run_needs_switch_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
      (extOpMode == MODE_EXT_ON && !q_r.clean[IDX_OPSW]) |=> !motorRun)
    else $error("ran in on setting with switch at halt");

  panel_only_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
      (extOpMode == MODE_PANEL && !q_r.clean[IDX_OPSW]) |=> !motorRun)
    else $error("panel mode ran with switch at halt");

  ext_dir_fixed_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
      (extOpMode == MODE_EXT_ONLY && q_r.clean[IDX_FWD]
       && !q_r.clean[IDX_REV]) |=> !motorCcw)
    else $error("external-only forward gave counterclockwise");

  release_decel_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
      (motorRun && extOpMode == MODE_EXT_ONLY && !q_r.clean[IDX_FWD]
       && !q_r.clean[IDX_REV]) |=> motorDecel)
    else $error("release did not decelerate");

  lock_hold_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
      (extOpMode == MODE_EXT_ONLY && q_r.clean[IDX_OPSW]) |=> lockoutShow)
    else $error("lockout not held with switch at run");

  no_lock_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
      (extOpMode != MODE_EXT_ONLY) |=> !lockoutShow)
    else $error("lockout shown outside external-only");

  locked_dial_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
      (lockFunction && !q_r.clean[IDX_DIAL]) |=> $stable(motorSpeed))
    else $error("speed changed while locked");

endmodule

`default_nettype wire

// file: hw/mrsc_pkg.sv
// Purpose: shared constants and types for the motor run/stop control
// Assumes: 20 MHz core clock
// Notes:   mode encoding follows the external operation setting
package mrsc_pkg;
  localparam logic [1:0] MODE_PANEL    = 2'h0;
  localparam logic [1:0] MODE_EXT_ON   = 2'h1;
  localparam logic [1:0] MODE_EXT_ONLY = 2'h2;
  localparam int CLK_HZ        = 20_000_000;
  localparam int LOCKOUT_MS    = 2000;
  localparam int LOCKOUT_CYC   = (CLK_HZ / 1000) * LOCKOUT_MS;
  localparam int DEBOUNCE_US   = 1000;
  localparam int DEBOUNCE_CYC  = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
  localparam int SPEED_W       = 12;
  localparam int NUM_IN        = 5;
  localparam int IDX_FWD       = 0;
  localparam int IDX_REV       = 1;
  localparam int IDX_OPSW      = 2;
  localparam int IDX_DIRSW     = 3;
  localparam int IDX_DIAL      = 4;
  localparam logic [SPEED_W-1:0] SPEED_RST = 12'h000;

  typedef enum logic [2:0] {
    ST_STOP  = 3'b001,
    ST_RUN   = 3'b010,
    ST_DECEL = 3'b100
  } mrsc_state_t;

  // motor command presented to the power stage
  typedef struct packed {
    logic               run;
    logic               decel;
    logic               brake;
    logic               ccw;
    logic [SPEED_W-1:0] speed;
  } mrsc_cmd_t;

  typedef struct packed {
    logic [NUM_IN-1:0] s1;
    logic [NUM_IN-1:0] s2;
    logic [NUM_IN-1:0] s3;
    logic [NUM_IN-1:0] clean;
    logic [NUM_IN-1:0][21:0] cnt;
    mrsc_state_t        st;
    logic               ccwHold;
    logic [SPEED_W-1:0] storedSpeed;
    logic [SPEED_W-1:0] dialSpeedPrev;
    logic               unconfirmed;
    logic [25:0]        lockCnt;
    logic               prevOp;
    logic               prevDir;
    logic               prevDial;
    mrsc_cmd_t          cmd;
    logic               lockout;
    logic               blink;
  } mrsc_state_all_t;
endpackage

// file: tb/mrsc_ctrl_model.sv
// Purpose: controller model that drives the external run inputs
// Assumes: commands from the bench change at the falling clock edge
// Notes:   levels are held until the next command, as a controller would
`timescale 1ns/1ns
`default_nettype none
module mrsc_ctrl_model (
  // clock and commands
  input  wire logic core_clk,
  input  wire logic cmdFwd,
  input  wire logic cmdRev,
  // run inputs toward the driver
  output var logic  forwardRunInput,
  output var logic  reverseRunInput
);
  initial begin
    forwardRunInput = 1'b0;
    reverseRunInput = 1'b0;
  end

  // both high together is a real command, used for the instant stop
  always @(negedge core_clk) begin
    forwardRunInput <= cmdFwd;
    reverseRunInput <= cmdRev;
  end
endmodule
`default_nettype wire

// file: tb/mrsc_top_tb.sv
// Purpose: self-checking bench for the run/stop control
// Assumes: full debounce length, so each row waits about 1 ms
// Notes:   lockout expiry is longer than the run and is not awaited
`timescale 1ns/1ns
`default_nettype none
module mrsc_top_tb import mrsc_pkg::*;;
  typedef struct packed {
    logic [1:0] mode;
    logic       forward_run_input;
    logic       reverse_run_input;
    logic       op;
    logic       dir;
    logic       chkLk;
    logic [3:0] mask;
    logic [3:0] exp;
  } mrsc_row_t;

  // command bits are run, decel, brake, ccw
  localparam int NROW = 4;
  localparam mrsc_row_t ROWS [NROW] = '{
    '{MODE_EXT_ONLY, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 4'h8},
    '{MODE_EXT_ONLY, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hA, 4'h2},
    '{MODE_EXT_ON,   1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 4'hB, 4'h8},
    '{MODE_EXT_ON,   1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'hC, 4'h4}
  };

  logic               core_clk;
  logic               arst_n;
  logic               cmdFwd;
  logic               cmdRev;
  logic               fwdIn;
  logic               revIn;
  logic               opSwitchRun;
  logic               dirSwitchRev;
  logic [1:0]         extOpMode;
  logic [SPEED_W-1:0] dialSpeed;
  logic               lockFunction;
  logic               monitorSpeedView;
  logic               motorRun;
  logic               motorDecel;
  logic               motorBrake;
  logic               motorCcw;
  logic [SPEED_W-1:0] motorSpeed;
  logic               lockoutShow;
  logic               displayBlink;
  int                 num_errors;
  int                 comparisons;

  mrsc_ctrl_model i_ctrl (
    .core_clk        (core_clk),
    .cmdFwd          (cmdFwd),
    .cmdRev          (cmdRev),
    .forwardRunInput (fwdIn),
    .reverseRunInput (revIn)
  );

  mrsc_top i_dut (
    .core_clk          (core_clk),
    .arst_n            (arst_n),
    .forwardRunInput   (fwdIn),
    .reverseRunInput   (revIn),
    .opSwitchRun       (opSwitchRun),
    .dirSwitchRev      (dirSwitchRev),
    .dialPress         (1'b0),
    .dialSpeed         (dialSpeed),
    .extOpMode         (extOpMode),
    .lockFunction      (lockFunction),
    .monitorSpeedView  (monitorSpeedView),
    .settingViewActive (1'b0),
    .motorRun          (motorRun),
    .motorDecel        (motorDecel),
    .motorBrake        (motorBrake),
    .motorCcw          (motorCcw),
    .motorSpeed        (motorSpeed),
    .lockoutShow       (lockoutShow),
    .displayBlink      (displayBlink)
  );

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  task automatic checkCmd(input logic [3:0] m, input logic [3:0] e);
    logic [3:0] got;
    got = {motorRun, motorDecel, motorBrake, motorCcw};
    comparisons++;
    if ((got & m) !== (e & m)) begin
      num_errors++;
      $display("Error at %0t: command %b, expected %b", $time, got, e);
    end
  endtask

  task automatic checkVal(input logic [SPEED_W-1:0] got,
                          input logic [SPEED_W-1:0] e);
    comparisons++;
    if (got !== e) begin
      num_errors++;
      $display("Error at %0t: value %h, expected %h", $time, got, e);
    end
  endtask

  task automatic print_verdict;
    $display("Counts: %0d comparisons, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (99000) @(posedge core_clk);
    num_errors++;
    $display("Error at %0t: run did not finish", $time);
    print_verdict;
  end

  initial begin
    num_errors   = 0;
    comparisons  = 0;
    arst_n       = 1'b0;
    cmdFwd       = 1'b0;
    cmdRev       = 1'b0;
    opSwitchRun  = 1'b0;
    dirSwitchRev = 1'b0;
    extOpMode    = MODE_PANEL;
    dialSpeed    = SPEED_RST;
    lockFunction = 1'b0;
    monitorSpeedView = 1'b0;
    repeat (16) @(negedge core_clk);
    checkCmd(4'hF, 4'h0);
    checkVal({11'h000, lockoutShow}, 12'h000);
    checkVal({11'h000, displayBlink}, 12'h000);
    $display("reset test done");
    arst_n = 1'b1;
    for (int i = 0; i < NROW; i++) begin
      extOpMode    = ROWS[i].mode;
      cmdFwd       = ROWS[i].forward_run_input;
      cmdRev       = ROWS[i].reverse_run_input;
      opSwitchRun  = ROWS[i].op;
      dirSwitchRev = ROWS[i].dir;
      // model lag, sync stages and debounce, with margin
      repeat (DEBOUNCE_CYC + 8) @(negedge core_clk);
      checkCmd(ROWS[i].mask, ROWS[i].exp);
      if (ROWS[i].chkLk) begin
        checkVal({11'h000, lockoutShow}, 12'h001);
      end
      checkVal(motorSpeed, SPEED_RST);
      $display("row %0d test done", i);
    end
    // dial is registered only once, so these need no debounce wait
    dialSpeed = 12'h0123;
    repeat (4) @(negedge core_clk);
    checkVal(motorSpeed, 12'h0123);
    checkVal({11'h000, displayBlink}, 12'h001);
    lockFunction = 1'b1;
    dialSpeed    = 12'h0456;
    repeat (4) @(negedge core_clk);
    checkVal(motorSpeed, 12'h0123);
    $display("dial test done");
    // external-only with reverse input held: switch side ignored
    lockFunction = 1'b0;
    extOpMode    = MODE_EXT_ONLY;
    repeat (4) @(negedge core_clk);
    checkCmd(4'hF, 4'h9);
    checkVal({11'h000, lockoutShow}, 12'h000);
    monitorSpeedView = 1'b1;
    dialSpeed        = 12'h0789;
    repeat (4) @(negedge core_clk);
    checkVal({11'h000, lockoutShow}, 12'h001);
    checkVal(motorSpeed, 12'h0123);
    $display("external-only dial test done");
    // asynchronous reset in mid-run drops the command at once
    #10 arst_n = 1'b0;
    #5 checkCmd(4'hF, 4'h0);
    checkVal({11'h000, lockoutShow}, 12'h000);
    $display("mid-run reset test done");
    print_verdict;
  end
endmodule
`default_nettype wire
